/* core/order_table_load_pkg.sv */
package order_table_load_pkg;
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  // register offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_RANGE = 8'h08;
  localparam logic [7:0] OFS_COUNT = 8'h0c;
  localparam logic [7:0] OFS_QPTR = 8'h10;
  localparam logic [7:0] OFS_SEQ_LOAD = 8'h14;
  localparam logic [7:0] OFS_SEQ_CLR = 8'h18;
  localparam logic [7:0] OFS_SEQ_READ = 8'h1c;
  localparam logic [7:0] OFS_VSET = 8'h20;
  localparam logic [7:0] OFS_TRAN_DUR = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;
  localparam logic [7:0] OFS_ERR = 8'h2c;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h30;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h34;
  // control fields
  localparam int CTRL_ORDER_BIT = 0;
  localparam int CTRL_DIR_BIT = 1;
  // status fields
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_ORDER_BIT = 1;
  localparam int STAT_ARMED_BIT = 2;
  localparam int STAT_TRAN_BIT = 3;
  localparam int STAT_QUARTER_BIT = 4;
  // interrupt bits
  localparam int IRQ_W = 3;
  localparam int IRQ_ERR_BIT = 0;
  localparam int IRQ_DONE_BIT = 1;
  localparam int IRQ_TRAN_BIT = 2;
  // error codes, two's complement
  localparam logic [15:0] ERR_SETTINGS = 16'hff23;
  localparam logic [15:0] ERR_RANGE = 16'hff22;
  localparam logic [15:0] ERR_NONE = 16'h0000;
  localparam logic [15:0] END_MARK = 16'hffff;
  // list geometry
  localparam int LOC_W = 10;
  localparam logic [9:0] MAX_LOC = 10'h03e9;
  localparam int SEQ_CELLS = 512;
  localparam logic [9:0] SEQ_FULL = 10'h0200;
  localparam logic [15:0] SEQ_MAX_VAL = 16'h01ff;
  localparam logic [4:0] QUERY_MAX = 5'h10;
  // range values
  localparam logic [15:0] RANGE_FULL = 16'h0001;
  localparam logic [15:0] RANGE_QUARTER = 16'h0004;
  // timing: dwell and transient counted in 1 ms ticks
  localparam int CLK_HZ = 20000000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = (CLK_HZ / 1000000) * TICK_US;
  // voltage modes and run states
  typedef enum logic [1:0] {
    VMODE_FIXED = 2'b00,
    VMODE_LIST = 2'b01,
    VMODE_TRAN = 2'b10
  } vmode_t;
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_RUN = 1'b1
  } run_state_t;
endpackage : order_table_load_pkg

/* core/list_sequencer.sv */
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
module list_sequencer #(
  parameter int TICK_CYCLES = order_table_load_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  // list memory outside this block
  input wire logic [9:0] volt_points,
  input wire logic [9:0] dwell_points,
  input wire logic [15:0] step_level,
  input wire logic [15:0] step_dwell,
  output logic [9:0] step_loc,
  output logic [9:0] query_ptr,
  // output control
  output logic [15:0] vset,
  output logic list_running,
  output logic quarter_scale,
  input wire logic trig,
  output logic tran_active,
  // interrupt
  output logic irq
);

  // address belongs to the list command group
  function automatic logic is_list_reg(input logic [7:0] a);
    return a == order_table_load_pkg::OFS_CTRL || a == order_table_load_pkg::OFS_COUNT ||
           a == order_table_load_pkg::OFS_QPTR || a == order_table_load_pkg::OFS_SEQ_LOAD ||
           a == order_table_load_pkg::OFS_SEQ_CLR || a == order_table_load_pkg::OFS_SEQ_READ;
  endfunction : is_list_reg

  order_table_load_pkg::run_state_t state_r;
  logic user_order_r;
  logic dir_down_r;
  logic [15:0] count_r;
  logic [15:0] rep_r;
  logic [9:0] qptr_r;
  logic [4:0] qidx_r;
  logic [8:0] seq_mem [0:order_table_load_pkg::SEQ_CELLS-1];
  logic [9:0] seq_len_r;
  logic [9:0] pos_r;
  logic apply_r;
  logic [15:0] dwell_r;
  logic [15:0] tran_dur_r;
  logic [15:0] tran_cnt_r;
  logic armed_r;
  logic [15:0] err_code_r;
  logic [2:0] irq_stat_r;
  logic [2:0] irq_mask_r;
  logic [1:0] trig_sync_r;
  logic trig_prev_r;
  logic [31:0] tick_cnt_r;
  logic tick;
  logic err_set;
  logic [15:0] err_val;
  logic accept;
  logic start_req;
  logic stop_req;
  logic [9:0] list_len;
  logic [9:0] first_pos;
  logic [9:0] last_pos;
  logic step_end;
  logic list_done;
  logic tran_done;
  logic trig_rise;
  logic [9:0] qcell;

  // millisecond tick enable
  always_ff @(posedge ref_clk) begin
    if (rst || tick) begin
      tick_cnt_r <= 32'h0000_0000;
    end else begin
      tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
    end
  end
  assign tick = tick_cnt_r == 32'(TICK_CYCLES - 1);

  // trigger pin synchroniser and edge
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      trig_sync_r <= 2'b00;
      trig_prev_r <= 1'b0;
    end else begin
      trig_sync_r <= {trig_sync_r[0], trig};
      trig_prev_r <= trig_sync_r[1];
    end
  end
  assign trig_rise = trig_sync_r[1] && !trig_prev_r;

  // command checking and error selection
  always_comb begin
    err_set = 1'b0;
    err_val = order_table_load_pkg::ERR_SETTINGS;
    if ((wr || rd) && list_running && is_list_reg(addr)) begin
      err_set = 1'b1;
    end else if (wr) begin
      unique case (addr)
        order_table_load_pkg::OFS_MODE: begin
          if (wdata[1:0] == 2'b11) begin
            err_set = 1'b1;
          end else if (wdata[1:0] == order_table_load_pkg::VMODE_LIST && !list_running &&
                       (volt_points != dwell_points || volt_points == 10'h000 ||
                        (user_order_r && seq_len_r == 10'h000))) begin
            err_set = 1'b1;
          end
        end
        order_table_load_pkg::OFS_RANGE: begin
          if (wdata != order_table_load_pkg::RANGE_FULL && wdata != order_table_load_pkg::RANGE_QUARTER) begin
            err_set = 1'b1;
            err_val = order_table_load_pkg::ERR_RANGE;
          end
        end
        order_table_load_pkg::OFS_QPTR: begin
          if (wdata > {6'h00, order_table_load_pkg::MAX_LOC}) begin
            err_set = 1'b1;
            err_val = order_table_load_pkg::ERR_RANGE;
          end
        end
        order_table_load_pkg::OFS_SEQ_LOAD: begin
          if (seq_len_r == order_table_load_pkg::SEQ_FULL) begin
            err_set = 1'b1;
          end else if (wdata > order_table_load_pkg::SEQ_MAX_VAL) begin
            err_set = 1'b1;
            err_val = order_table_load_pkg::ERR_RANGE;
          end
        end
        default: begin
        end
      endcase
    end
  end
  assign accept = wr && !err_set;
  assign start_req = accept && addr == order_table_load_pkg::OFS_MODE && !list_running &&
                     wdata[1:0] == order_table_load_pkg::VMODE_LIST;
  assign stop_req = accept && addr == order_table_load_pkg::OFS_MODE &&
                    wdata[1:0] != order_table_load_pkg::VMODE_LIST;

  // configuration registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      user_order_r <= 1'b0;
      dir_down_r <= 1'b0;
      count_r <= 16'h0001;
      qptr_r <= 10'h000;
      quarter_scale <= 1'b0;
      tran_dur_r <= 16'h0001;
      irq_mask_r <= 3'b000;
    end else if (accept) begin
      unique case (addr)
        order_table_load_pkg::OFS_CTRL: begin
          user_order_r <= wdata[order_table_load_pkg::CTRL_ORDER_BIT];
          dir_down_r <= wdata[order_table_load_pkg::CTRL_DIR_BIT];
        end
        order_table_load_pkg::OFS_COUNT: count_r <= wdata;
        order_table_load_pkg::OFS_QPTR: qptr_r <= wdata[9:0];
        order_table_load_pkg::OFS_RANGE: quarter_scale <= wdata == order_table_load_pkg::RANGE_QUARTER;
        order_table_load_pkg::OFS_TRAN_DUR: tran_dur_r <= wdata;
        order_table_load_pkg::OFS_IRQ_MASK: irq_mask_r <= wdata[2:0];
        default: begin
        end
      endcase
    end
  end
  assign query_ptr = qptr_r;

  // user order table fill
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      seq_len_r <= 10'h000;
    end else if (accept && addr == order_table_load_pkg::OFS_SEQ_CLR) begin
      seq_len_r <= 10'h000;
    end else if (accept && addr == order_table_load_pkg::OFS_SEQ_LOAD) begin
      seq_mem[seq_len_r[8:0]] <= wdata[8:0];
      seq_len_r <= seq_len_r + 10'h001;
    end
  end

  // walk geometry for the selected order
  assign list_len = user_order_r ? seq_len_r : volt_points;
  assign first_pos = dir_down_r ? list_len - 10'h001 : 10'h000;
  assign last_pos = dir_down_r ? 10'h000 : list_len - 10'h001;
  assign step_loc = user_order_r ? {1'b0, seq_mem[pos_r[8:0]]} : pos_r;
  assign step_end = state_r == order_table_load_pkg::ST_RUN && !apply_r && tick && dwell_r == 16'h0001;
  assign list_done = step_end && pos_r == last_pos && count_r != 16'h0000 &&
                     rep_r + 16'h0001 >= count_r;

  // list execution
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_r <= order_table_load_pkg::ST_IDLE;
      pos_r <= 10'h000;
      rep_r <= 16'h0000;
      apply_r <= 1'b0;
      dwell_r <= 16'h0000;
      vset <= 16'h0000;
    end else if (stop_req) begin
      state_r <= order_table_load_pkg::ST_IDLE;
      apply_r <= 1'b0;
    end else begin
      unique case (state_r)
        order_table_load_pkg::ST_IDLE: begin
          if (accept && addr == order_table_load_pkg::OFS_VSET) begin
            vset <= wdata;
          end
          if (start_req) begin
            state_r <= order_table_load_pkg::ST_RUN;
            pos_r <= first_pos;
            rep_r <= 16'h0000;
            apply_r <= 1'b1;
          end
        end
        order_table_load_pkg::ST_RUN: begin
          if (apply_r) begin
            vset <= step_level;
            dwell_r <= (step_dwell == 16'h0000) ? 16'h0001 : step_dwell;
            apply_r <= 1'b0;
          end else if (list_done) begin
            state_r <= order_table_load_pkg::ST_IDLE;
          end else if (step_end) begin
            apply_r <= 1'b1;
            if (pos_r == last_pos) begin
              pos_r <= first_pos;
              rep_r <= rep_r + 16'h0001;
            end else if (dir_down_r) begin
              pos_r <= pos_r - 10'h001;
            end else begin
              pos_r <= pos_r + 10'h001;
            end
          end else if (tick) begin
            dwell_r <= dwell_r - 16'h0001;
          end
        end
      endcase
    end
  end
  assign list_running = state_r == order_table_load_pkg::ST_RUN;

  // voltage transient arm and hold
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      armed_r <= 1'b0;
      tran_active <= 1'b0;
      tran_cnt_r <= 16'h0000;
    end else if (accept && addr == order_table_load_pkg::OFS_MODE) begin
      armed_r <= wdata[1:0] == order_table_load_pkg::VMODE_TRAN;
      tran_active <= 1'b0;
    end else if (armed_r && trig_rise) begin
      armed_r <= 1'b0;
      tran_active <= 1'b1;
      tran_cnt_r <= (tran_dur_r == 16'h0000) ? 16'h0001 : tran_dur_r;
    end else if (tran_active && tick) begin
      tran_cnt_r <= tran_cnt_r - 16'h0001;
      if (tran_cnt_r == 16'h0001) begin
        tran_active <= 1'b0;
      end
    end
  end
  assign tran_done = tran_active && tick && tran_cnt_r == 16'h0001 &&
                     !(accept && addr == order_table_load_pkg::OFS_MODE);

  // error code and sticky interrupt bits, set beats clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      err_code_r <= order_table_load_pkg::ERR_NONE;
      irq_stat_r <= 3'b000;
    end else begin
      if (err_set) begin
        err_code_r <= err_val;
      end else if (wr && addr == order_table_load_pkg::OFS_ERR) begin
        err_code_r <= order_table_load_pkg::ERR_NONE;
      end
      irq_stat_r <= (irq_stat_r & ~((wr && addr == order_table_load_pkg::OFS_IRQ_STAT) ? wdata[2:0] : 3'b000))
                    | {tran_done, list_done, err_set};
    end
  end
  assign irq = |(irq_stat_r & irq_mask_r);

  // register read-back, one cycle after the strobe
  assign qcell = qptr_r + {5'h00, qidx_r};
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata <= 16'h0000;
      qidx_r <= 5'h00;
    end else begin
      rdata <= 16'h0000;
      if (accept && addr == order_table_load_pkg::OFS_QPTR) begin
        qidx_r <= 5'h00;
      end
      if (rd && !(list_running && is_list_reg(addr))) begin
        unique case (addr)
          order_table_load_pkg::OFS_CTRL: rdata <= {14'h0000, dir_down_r, user_order_r};
          order_table_load_pkg::OFS_MODE: rdata <= {14'h0000, armed_r, list_running};
          order_table_load_pkg::OFS_RANGE: rdata <= quarter_scale ? order_table_load_pkg::RANGE_QUARTER :
                                            order_table_load_pkg::RANGE_FULL;
          order_table_load_pkg::OFS_COUNT: rdata <= count_r;
          order_table_load_pkg::OFS_QPTR: rdata <= {6'h00, qptr_r};
          order_table_load_pkg::OFS_SEQ_LOAD: rdata <= {6'h00, seq_len_r};
          order_table_load_pkg::OFS_SEQ_READ: begin
            if (qidx_r < order_table_load_pkg::QUERY_MAX && qcell < seq_len_r) begin
              rdata <= {7'h00, seq_mem[qcell[8:0]]};
              qidx_r <= qidx_r + 5'h01;
            end else begin
              rdata <= order_table_load_pkg::END_MARK;
            end
          end
          order_table_load_pkg::OFS_VSET: rdata <= vset;
          order_table_load_pkg::OFS_TRAN_DUR: rdata <= tran_dur_r;
          order_table_load_pkg::OFS_STATUS: rdata <= {11'h000, quarter_scale, tran_active, armed_r,
                                              user_order_r, list_running};
          order_table_load_pkg::OFS_ERR: rdata <= err_code_r;
          order_table_load_pkg::OFS_IRQ_STAT: rdata <= {13'h0000, irq_stat_r};
          order_table_load_pkg::OFS_IRQ_MASK: rdata <= {13'h0000, irq_mask_r};
          default: rdata <= 16'h0000;
        endcase
      end
    end
  end

  // checks on the block's own behaviour
  a_busy_list_err: assert property (@(posedge ref_clk) disable iff (rst)
    (wr || rd) && list_running && is_list_reg(addr) |=> err_code_r == order_table_load_pkg::ERR_SETTINGS)
    else $error("list access while running did not post -221");
  a_fixed_halts: assert property (@(posedge ref_clk) disable iff (rst)
    wr && addr == order_table_load_pkg::OFS_MODE && wdata[1:0] == order_table_load_pkg::VMODE_FIXED
    |=> !list_running)
    else $error("fixed mode did not halt the list");
  a_unequal_refused: assert property (@(posedge ref_clk) disable iff (rst)
    wr && addr == order_table_load_pkg::OFS_MODE && wdata[1:0] == order_table_load_pkg::VMODE_LIST &&
    !list_running && volt_points != dwell_points
    |=> !list_running && err_code_r == order_table_load_pkg::ERR_SETTINGS)
    else $error("unbalanced lists were executed");
  a_apply_level: assert property (@(posedge ref_clk) disable iff (rst)
    list_running && apply_r && !stop_req |=> vset == $past(step_level))
    else $error("step level not applied to voltage setting");
  a_forever_loop: assert property (@(posedge ref_clk) disable iff (rst)
    step_end && count_r == 16'h0000 && !stop_req |=> list_running)
    else $error("list with zero count stopped by itself");
  a_table_full: assert property (@(posedge ref_clk) disable iff (rst)
    wr && addr == order_table_load_pkg::OFS_SEQ_LOAD && seq_len_r == order_table_load_pkg::SEQ_FULL
    |=> seq_len_r == order_table_load_pkg::SEQ_FULL)
    else $error("order table grew beyond its cells");
  a_range_quarter: assert property (@(posedge ref_clk) disable iff (rst)
    wr && addr == order_table_load_pkg::OFS_RANGE && wdata == order_table_load_pkg::RANGE_QUARTER
    |=> quarter_scale)
    else $error("range 4 did not select quarter scale");
  a_qptr_range: assert property (@(posedge ref_clk) disable iff (rst)
    qptr_r <= order_table_load_pkg::MAX_LOC)
    else $error("query pointer beyond last location");
  a_tran_start: assert property (@(posedge ref_clk) disable iff (rst)
    armed_r && trig_rise && !wr |=> tran_active && !armed_r)
    else $error("armed transient did not start on trigger");
  a_walk_step: assert property (@(posedge ref_clk) disable iff (rst)
    step_end && !list_done && pos_r != last_pos && !stop_req
    |=> pos_r == ($past(dir_down_r) ? $past(pos_r) - 10'h001 : $past(pos_r) + 10'h001))
    else $error("list position did not move by one");
  c_list_done: cover property (@(posedge ref_clk) disable iff (rst) list_done);
  c_user_run: cover property (@(posedge ref_clk) disable iff (rst) list_running && user_order_r);
  c_busy_err: cover property (@(posedge ref_clk) disable iff (rst)
    rd && list_running && is_list_reg(addr));
  c_tran_done: cover property (@(posedge ref_clk) disable iff (rst) tran_done);

endmodule : list_sequencer

/* dv/list_mem_model.sv */
`timescale 1ns/1ps
// list memory at the far side: level looked up by location, dwell the same DWELL for every location
module list_mem_model #(
  parameter logic [15:0] DWELL = 16'h0001
) (
  // location from the sequencer
  input wire logic [9:0] step_loc,
  // stored step data
  output logic [15:0] step_level,
  output logic [15:0] step_dwell
);
  // level encodes the location so every step is distinguishable
  assign step_level = 16'h1000 + {6'h00, step_loc};
  assign step_dwell = DWELL;
endmodule : list_mem_model

/* dv/list_sequence_control_tb.sv */
`timescale 1ns/1ps
module list_sequence_control_tb;
  logic ref_clk, rst, wr, rd, trig;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, step_level, step_dwell, vset;
  logic [9:0] volt_points, dwell_points, step_loc, query_ptr;
  logic list_running, quarter_scale, tran_active, irq;
  int err_total, tests_run, cyc;
  list_sequencer #(.TICK_CYCLES(4)) i_list_sequencer (.ref_clk(ref_clk), .rst(rst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .volt_points(volt_points),
    .dwell_points(dwell_points), .step_level(step_level), .step_dwell(step_dwell),
    .step_loc(step_loc), .query_ptr(query_ptr), .vset(vset), .list_running(list_running),
    .quarter_scale(quarter_scale), .trig(trig), .tran_active(tran_active), .irq(irq));
  list_mem_model i_list_mem_model (.step_loc(step_loc), .step_level(step_level),
    .step_dwell(step_dwell));
  // 20 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk
  // one write cycle
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wr_reg
  // one read cycle, data taken in the following cycle
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp, input string what);
    logic [15:0] d;
    rd_reg(a, d);
    chk(d, exp, what);
  endtask : rd_chk
  // start a list and record the locations it walks
  task automatic run_seq(input logic [9:0] e0, e1, e2, input string what);
    logic [9:0] seen[$];
    logic [9:0] last;
    int n;
    wr_reg(order_table_load_pkg::OFS_MODE, 16'h0001);
    #1;
    n = 0;
    while (list_running !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      #1 n++;
    end
    seen.push_back(step_loc);
    last = step_loc;
    n = 0;
    while (list_running === 1'b1 && n < 500) begin
      @(posedge ref_clk);
      #1 n++;
      if (list_running === 1'b1 && step_loc !== last) begin
        seen.push_back(step_loc);
        last = step_loc;
      end
    end
    chk(16'(seen.size()), 16'h0003, what);
    if (seen.size() == 3) begin
      chk({6'h00, seen[0]}, {6'h00, e0}, what);
      chk({6'h00, seen[1]}, {6'h00, e1}, what);
      chk({6'h00, seen[2]}, {6'h00, e2}, what);
    end
    chk(vset, 16'h1000 + {6'h00, e2}, "vset after end");
  endtask : run_seq
  task automatic t_reset();
    chk({12'h000, quarter_scale, tran_active, list_running, irq}, 16'h0000, "idle outputs");
    rd_chk(order_table_load_pkg::OFS_COUNT, 16'h0001, "count reset");
    rd_chk(order_table_load_pkg::OFS_VSET, 16'h0000, "vset reset");
    rd_chk(8'hfc, 16'h0000, "unmapped read");
    $display("test reset done");
  endtask : t_reset
  task automatic t_order_sel();
    wr_reg(order_table_load_pkg::OFS_CTRL, 16'h0001);
    rd_chk(order_table_load_pkg::OFS_CTRL, 16'h0001, "user order shown");
    rd_chk(order_table_load_pkg::OFS_STATUS, 16'h0002, "status user");
    wr_reg(order_table_load_pkg::OFS_CTRL, 16'h0000);
    rd_chk(order_table_load_pkg::OFS_CTRL, 16'h0000, "default order shown");
    $display("test order select done");
  endtask : t_order_sel
  task automatic t_qptr();
    wr_reg(order_table_load_pkg::OFS_QPTR, 16'h03e9);
    #1 chk({6'h00, query_ptr}, 16'h03e9, "qptr max");
    wr_reg(order_table_load_pkg::OFS_QPTR, 16'h03ea);
    #1 chk({6'h00, query_ptr}, 16'h03e9, "qptr over refused");
    rd_chk(order_table_load_pkg::OFS_ERR, order_table_load_pkg::ERR_RANGE, "qptr range error");
    rd_chk(order_table_load_pkg::OFS_QPTR, 16'h03e9, "qptr readback");
    wr_reg(order_table_load_pkg::OFS_ERR, 16'h0000);
    $display("test query pointer done");
  endtask : t_qptr
  // the host keeps table loads to what these checks need
  task automatic t_table();
    wr_reg(order_table_load_pkg::OFS_SEQ_CLR, 16'h0000);
    for (int k = 0; k < 512; k++) wr_reg(order_table_load_pkg::OFS_SEQ_LOAD, 16'(k));
    wr_reg(order_table_load_pkg::OFS_SEQ_LOAD, 16'h0000);
    rd_chk(order_table_load_pkg::OFS_ERR, order_table_load_pkg::ERR_SETTINGS, "load past 512");
    rd_chk(order_table_load_pkg::OFS_SEQ_LOAD, 16'h0200, "fill count");
    wr_reg(order_table_load_pkg::OFS_QPTR, 16'h01f4);
    for (int k = 0; k < 17; k++)
      rd_chk(order_table_load_pkg::OFS_SEQ_READ, (k < 12) ? 16'(500 + k) : 16'hffff, "window");
    // a full table still stops after sixteen cells
    wr_reg(order_table_load_pkg::OFS_QPTR, 16'h0000);
    for (int k = 0; k < 17; k++)
      rd_chk(order_table_load_pkg::OFS_SEQ_READ, (k < 16) ? 16'(k) : 16'hffff, "sixteen cap");
    wr_reg(order_table_load_pkg::OFS_SEQ_CLR, 16'h0000);
    wr_reg(order_table_load_pkg::OFS_SEQ_LOAD, 16'h0001);
    wr_reg(order_table_load_pkg::OFS_SEQ_LOAD, 16'h0001);
    wr_reg(order_table_load_pkg::OFS_SEQ_LOAD, 16'h0200);
    rd_chk(order_table_load_pkg::OFS_ERR, order_table_load_pkg::ERR_RANGE, "value over 511");
    wr_reg(order_table_load_pkg::OFS_QPTR, 16'h0000);
    rd_chk(order_table_load_pkg::OFS_SEQ_READ, 16'h0001, "repeat cell 0");
    rd_chk(order_table_load_pkg::OFS_SEQ_READ, 16'h0001, "repeat cell 1");
    rd_chk(order_table_load_pkg::OFS_SEQ_READ, 16'hffff, "past fill");
    wr_reg(order_table_load_pkg::OFS_ERR, 16'h0000);
    $display("test order table done");
  endtask : t_table
  task automatic t_runs();
    volt_points <= 10'h003;
    dwell_points <= 10'h003;
    wr_reg(order_table_load_pkg::OFS_IRQ_MASK, 16'h0002);
    run_seq(10'h000, 10'h001, 10'h002, "default up");
    chk({15'h0000, irq}, 16'h0001, "done irq");
    wr_reg(order_table_load_pkg::OFS_IRQ_STAT, 16'h0002);
    #1 chk({15'h0000, irq}, 16'h0000, "done irq cleared");
    wr_reg(order_table_load_pkg::OFS_SEQ_CLR, 16'h0000);
    wr_reg(order_table_load_pkg::OFS_SEQ_LOAD, 16'h0002);
    wr_reg(order_table_load_pkg::OFS_SEQ_LOAD, 16'h0000);
    wr_reg(order_table_load_pkg::OFS_SEQ_LOAD, 16'h0001);
    wr_reg(order_table_load_pkg::OFS_CTRL, 16'h0003);
    run_seq(10'h001, 10'h000, 10'h002, "user down");
    wr_reg(order_table_load_pkg::OFS_CTRL, 16'h0002);
    run_seq(10'h002, 10'h001, 10'h000, "default down");
    $display("test list runs done");
  endtask : t_runs
  task automatic t_forever();
    logic [9:0] loc;
    int n;
    wr_reg(order_table_load_pkg::OFS_IRQ_MASK, 16'h0001);
    wr_reg(order_table_load_pkg::OFS_IRQ_STAT, 16'h0007);
    #1 chk({15'h0000, irq}, 16'h0000, "error irq clear");
    wr_reg(order_table_load_pkg::OFS_COUNT, 16'h0000);
    wr_reg(order_table_load_pkg::OFS_MODE, 16'h0001);
    repeat (150) @(posedge ref_clk);
    #1 chk({15'h0000, list_running}, 16'h0001, "still running");
    rd_chk(order_table_load_pkg::OFS_CTRL, 16'h0000, "read refused");
    chk({15'h0000, irq}, 16'h0001, "error irq");
    rd_chk(order_table_load_pkg::OFS_ERR, order_table_load_pkg::ERR_SETTINGS, "busy error");
    // stop just after a step is applied, so no step is left pending
    loc = step_loc;
    n = 0;
    while (step_loc === loc && n < 50) begin
      @(posedge ref_clk);
      #1 n++;
    end
    loc = step_loc;
    wr_reg(order_table_load_pkg::OFS_MODE, 16'h0000);
    #1 chk({15'h0000, list_running}, 16'h0000, "halted");
    chk(vset, 16'h1000 + {6'h00, loc}, "last step kept");
    wr_reg(order_table_load_pkg::OFS_IRQ_STAT, 16'h0007);
    wr_reg(order_table_load_pkg::OFS_ERR, 16'h0000);
    dwell_points <= 10'h002;
    wr_reg(order_table_load_pkg::OFS_MODE, 16'h0001);
    #1 chk({15'h0000, list_running}, 16'h0000, "unequal lists refused");
    rd_chk(order_table_load_pkg::OFS_ERR, order_table_load_pkg::ERR_SETTINGS, "unequal error");
    $display("test forever and stop done");
  endtask : t_forever
  task automatic t_tran_range();
    int n;
    wr_reg(order_table_load_pkg::OFS_RANGE, 16'h0004);
    #1 chk({15'h0000, quarter_scale}, 16'h0001, "quarter");
    wr_reg(order_table_load_pkg::OFS_RANGE, 16'h0002);
    #1 chk({15'h0000, quarter_scale}, 16'h0001, "bad range ignored");
    wr_reg(order_table_load_pkg::OFS_TRAN_DUR, 16'h0002);
    wr_reg(order_table_load_pkg::OFS_MODE, 16'h0002);
    rd_chk(order_table_load_pkg::OFS_STATUS, 16'h0014, "armed");
    @(posedge ref_clk);
    trig <= 1'b1;
    n = 0;
    while (tran_active !== 1'b1 && n < 10) begin
      @(posedge ref_clk);
      #1 n++;
    end
    n = 0;
    while (tran_active === 1'b1 && n < 50) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk({15'h0000, n >= 5 && n <= 8}, 16'h0001, "hold length");
    trig <= 1'b0;
    $display("test transient and range done");
  endtask : t_tran_range
  // main sequence
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    trig = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    volt_points = 10'h003;
    dwell_points = 10'h003;
    err_total = 0;
    tests_run = 0;
    cyc = 0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_order_sel();
    t_qptr();
    t_table();
    t_runs();
    t_forever();
    t_tran_range();
    tally_and_finish();
  end
endmodule : list_sequence_control_tb
